// ==== core/cbu_branch_unit.sv ====
// Conditional relative branch unit: decides and updates the program counter.
`timescale 1ns/1ps
`include "cbu_params.svh"
module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int PC_W  = `CBU_PC_W,
  parameter int OFS_W = `CBU_OFS_W
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              issue,
  input  wire logic [3:0]        branch_kind,
  input  wire logic [OFS_W-1:0]  offset,
  input  wire logic [7:0]        sreg_in,
  output logic      [PC_W-1:0]   pc,
  output logic                   busy,
  output logic                   done,
  output logic                   taken,
  output logic      [7:0]        sreg_out
);
  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (OFS_W < 2 || OFS_W >= PC_W || PC_W > 32) begin
      $error("cbu_branch_unit: unsupported PC_W/OFS_W");
    end
  end

  // ****************************************
  // Condition evaluation
  // ****************************************
  cbu_cond_if cif ();
  cbu_cond_eval u_eval (
    .cif (cif)
  );

  assign cif.kind = cbu_branch_t'(branch_kind);
  assign cif.sreg = sreg_in;

  cbu_state_t          state_ff;
  cbu_state_t          nxt_state;
  logic [PC_W-1:0]     pc_ff;
  logic [PC_W-1:0]     nxt_pc;
  logic [PC_W-1:0]     target_ff;
  logic                busy_ff;
  logic                done_ff;
  logic                taken_ff;
  logic [7:0]          sreg_ff;

  // Sign-extended offset plus one, added to the branch word's address
  wire [PC_W-1:0] ofs_ext  = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};
  wire [PC_W-1:0] pc_seq   = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_jump  = pc_seq + ofs_ext;
  wire            accept   = issue && (state_ff == CBU_ST_IDLE) && cif.is_branch;
  wire            go_jump  = accept && cif.taken;
  wire            go_skip  = accept && !cif.taken;

  // ****************************************
  // Sequencer
  // ****************************************
  // Taken branches spend a second clock so the new target can be fetched
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    case (state_ff)
      CBU_ST_IDLE: begin
        if (go_jump) begin
          nxt_state = CBU_ST_SECOND;
        end else if (go_skip) begin
          nxt_pc = pc_seq;
        end
      end
      CBU_ST_SECOND: begin
        nxt_state = CBU_ST_IDLE;
        nxt_pc    = target_ff;
      end
      default: begin
        nxt_state = CBU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff  <= CBU_ST_IDLE;
      pc_ff     <= `CBU_PC_RESET;
      target_ff <= `CBU_PC_RESET;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      taken_ff  <= 1'b0;
      sreg_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      if (go_jump) begin
        target_ff <= pc_jump;
      end
      busy_ff  <= go_jump;
      done_ff  <= go_skip || (state_ff == CBU_ST_SECOND);
      if (accept) begin
        taken_ff <= cif.taken;
      end
      // Flags pass through untouched
      sreg_ff  <= sreg_in;
    end
  end

  assign pc       = pc_ff;
  assign busy     = busy_ff;
  assign done     = done_ff;
  assign taken    = taken_ff;
  assign sreg_out = sreg_ff;
endmodule : cbu_branch_unit

// ==== shared/cbu_params.svh ====
// Constants for the conditional branch unit.
`ifndef CBU_PARAMS_SVH
`define CBU_PARAMS_SVH
`define CBU_PC_W      16
`define CBU_OFS_W     7
`define CBU_SEL_W     4
`define CBU_PC_RESET  16'h0000
`define CBU_TAKEN_CYC 2
`define CBU_SKIP_CYC  1
`endif

// ==== shared/cbu_pkg.sv ====
// Types for the conditional branch unit.
package cbu_pkg;
  typedef enum logic [3:0] {
    CBU_BR_NONE        = 4'h0,
    CBU_BR_LOWER       = 4'h1,
    CBU_BR_SAME_HIGHER = 4'h2,
    CBU_BR_NEG_SET     = 4'h3,
    CBU_BR_NEG_CLEAR   = 4'h4,
    CBU_BR_SIGNED_GE   = 4'h5,
    CBU_BR_SIGNED_LESS = 4'h6,
    CBU_BR_HALF_SET    = 4'h7,
    CBU_BR_HALF_CLEAR  = 4'h8,
    CBU_BR_TBIT_SET    = 4'h9
  } cbu_branch_t;
  typedef enum logic [1:0] {
    CBU_ST_IDLE   = 2'b00,
    CBU_ST_SECOND = 2'b01
  } cbu_state_t;
endpackage : cbu_pkg

// ==== shared/cbu_cond_if.sv ====
// Condition request and verdict between the branch unit and its evaluator.
`timescale 1ns/1ps
interface cbu_cond_if;
  import cbu_pkg::*;
  cbu_branch_t kind;
  logic [7:0]  sreg;
  logic        taken;
  logic        is_branch;
  modport requester (output kind, output sreg, input taken, input is_branch);
  modport evaluator (input kind, input sreg, output taken, output is_branch);
endinterface : cbu_cond_if

// ==== core/cbu_cond_eval.sv ====
// Combinational branch condition evaluator.
`timescale 1ns/1ps
module cbu_cond_eval
  import cbu_pkg::*;
(
  cbu_cond_if.evaluator cif
);
  // Status byte order: I T H S V N Z C
  wire flag_c = cif.sreg[0];
  wire flag_n = cif.sreg[2];
  wire flag_v = cif.sreg[3];
  wire flag_h = cif.sreg[5];
  wire flag_t = cif.sreg[6];
  wire nv_xor = flag_n ^ flag_v;

  function automatic logic cbu_cond(input cbu_branch_t k, input logic c, input logic n, input logic nv,
                                    input logic h, input logic t);
    case (k)
      CBU_BR_LOWER:       cbu_cond = c;
      CBU_BR_SAME_HIGHER: cbu_cond = ~c;
      CBU_BR_NEG_SET:     cbu_cond = n;
      CBU_BR_NEG_CLEAR:   cbu_cond = ~n;
      CBU_BR_SIGNED_GE:   cbu_cond = ~nv;
      CBU_BR_SIGNED_LESS: cbu_cond = nv;
      CBU_BR_HALF_SET:    cbu_cond = h;
      CBU_BR_HALF_CLEAR:  cbu_cond = ~h;
      CBU_BR_TBIT_SET:    cbu_cond = t;
      default:            cbu_cond = 1'b0;
    endcase
  endfunction : cbu_cond

  assign cif.taken     = cbu_cond(cif.kind, flag_c, flag_n, nv_xor, flag_h, flag_t);
  assign cif.is_branch = (cif.kind != CBU_BR_NONE) && (cif.kind <= CBU_BR_TBIT_SET);
endmodule : cbu_cond_eval

// ==== testbench/cbu_branch_unit_sva.sv ====
// Port checks for the branch unit.
`timescale 1ns/1ps
module cbu_branch_unit_sva (
  input logic        clk, sys_rst, issue, busy, done, taken,
  input logic [3:0]  branch_kind,
  input logic [6:0]  offset,
  input logic [7:0]  sreg_in, sreg_out,
  input logic [15:0] pc
);
  logic [9:0]  hit;
  logic [15:0] tgt_ff;
  // Codes above 9 shift out
  assign hit = (issue && !busy) ? 10'h1 << branch_kind : 10'h0;
  always_ff @(posedge clk) begin
    if (|hit[9:1]) begin
      tgt_ff <= pc + {{9{offset[6]}}, offset} + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lower_jump: assert property (hit[1] && sreg_in[0] |=> taken) else $error("lower");
  a_minus_jump: assert property (hit[3] && sreg_in[2] |=> taken) else $error("minus");
  a_plus_jump: assert property (hit[4] && !sreg_in[2] |=> taken) else $error("plus");
  a_ge_jump: assert property (hit[5] && sreg_in[2] == sreg_in[3] |=> taken) else $error("ge");
  a_lt_jump: assert property (hit[6] && sreg_in[2] != sreg_in[3] |=> taken) else $error("lt");
  a_hset_jump: assert property (hit[7] && sreg_in[5] |=> taken) else $error("hset");
  a_hclr_jump: assert property (hit[8] && !sreg_in[5] |=> taken) else $error("hclr");
  a_tset_jump: assert property (hit[9] && sreg_in[6] |=> taken) else $error("tset");
  a_taken_target: assert property (|hit[9:1] ##1 taken |-> busy ##1 done && !busy && pc == tgt_ff)
    else $error("target");
  a_skip_step: assert property (|hit[9:1] ##1 !taken |-> done && !busy && pc == $past(pc) + 16'h1)
    else $error("skip");
endmodule : cbu_branch_unit_sva
bind cbu_branch_unit cbu_branch_unit_sva i_sva (.*);

// ==== testbench/cbu_branch_unit_test.sv ====
// Directed bench for the branch unit.
`timescale 1ns/1ps
module cbu_branch_unit_test;
  import cbu_pkg::*;
  logic        clk, sys_rst, issue, busy, done, taken;
  logic [3:0]  branch_kind;
  logic [6:0]  offset;
  logic [7:0]  sreg_in, sreg_out;
  logic [15:0] pc, exp_pc;
  int          errors, total_checks, cyc;
  cbu_branch_unit i_cbu_branch_unit (.*);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task chk(input logic [23:0] got, want);
    total_checks++;
    if (got !== want) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, got, want);
    end
  endtask : chk
  // Flags must pass through untouched, verdict and busy land one clock on
  task br(input logic [3:0] k, input logic [7:0] s, input logic [6:0] o, input logic j);
    @(posedge clk);
    #1 issue = 1;
    branch_kind = k;
    sreg_in = s;
    offset = o;
    exp_pc = exp_pc + (j ? {{9{o[6]}}, o} + 16'h1 : 16'h1);
    @(posedge clk);
    #1 issue = 0;
    chk({14'h0, taken, busy, sreg_out}, {14'h0, j, j, s});
    if (j) begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, done, pc}, {8'h1, exp_pc});
  endtask : br
  task t_carry;
    br(CBU_BR_LOWER, 8'h01, 7'h05, 1'b1);
    br(CBU_BR_LOWER, 8'hfe, 7'h05, 1'b0);
    br(CBU_BR_SAME_HIGHER, 8'h00, 7'h7e, 1'b1);
    $display("carry done");
  endtask : t_carry
  task t_sign;
    br(CBU_BR_NEG_SET, 8'h04, 7'h40, 1'b1);
    br(CBU_BR_NEG_CLEAR, 8'h04, 7'h3f, 1'b0);
    br(CBU_BR_NEG_CLEAR, 8'hfb, 7'h3f, 1'b1);
    br(CBU_BR_SIGNED_GE, 8'h0c, 7'h01, 1'b1);
    br(CBU_BR_SIGNED_LESS, 8'h0c, 7'h01, 1'b0);
    br(CBU_BR_SIGNED_LESS, 8'h08, 7'h02, 1'b1);
    $display("sign done");
  endtask : t_sign
  task t_flag;
    br(CBU_BR_HALF_SET, 8'h20, 7'h10, 1'b1);
    br(CBU_BR_HALF_CLEAR, 8'h20, 7'h10, 1'b0);
    br(CBU_BR_HALF_CLEAR, 8'hdf, 7'h7f, 1'b1);
    br(CBU_BR_TBIT_SET, 8'hbf, 7'h01, 1'b0);
    br(CBU_BR_TBIT_SET, 8'h40, 7'h01, 1'b1);
    $display("flag done");
  endtask : t_flag
  // Invalid codes and issue held while busy must be ignored
  task t_refuse;
    @(posedge clk);
    #1 issue = 1;
    branch_kind = 4'ha;
    @(posedge clk);
    #1 issue = 0;
    chk({7'h0, done, pc}, {8'h0, exp_pc});
    @(posedge clk);
    #1 issue = 1;
    branch_kind = CBU_BR_NEG_SET;
    sreg_in = 8'h04;
    offset = 7'h02;
    exp_pc = exp_pc + 16'h3;
    @(posedge clk);
    #1;
    chk({14'h0, taken, busy, sreg_out}, {14'h0, 1'b1, 1'b1, 8'h04});
    @(posedge clk);
    #1 issue = 0;
    chk({7'h0, done, pc}, {8'h1, exp_pc});
    @(posedge clk);
    #1;
    chk({7'h0, done, pc}, {8'h0, exp_pc});
    $display("refuse done");
  endtask : t_refuse
  initial begin
    sys_rst = 1;
    issue = 0;
    branch_kind = 4'h0;
    offset = 7'h00;
    sreg_in = 8'h00;
    exp_pc = 16'h0000;
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    chk({7'h0, done, pc}, 24'h0);
    chk({14'h0, taken, busy, sreg_out}, 24'h0);
    t_carry();
    t_sign();
    t_flag();
    t_refuse();
    final_report();
  end
  // About 55 clocks expected
  always @(posedge clk) begin
    cyc++;
    if (cyc > 200) begin
      errors++;
      final_report();
    end
  end
endmodule : cbu_branch_unit_test
